// File: rtl/ccg_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccg_cfg.svh"
module ccg_top
	import ccg_pkg::*;
#(
	parameter int PER_W = `CCG_PER_W,
	parameter int DIV_W = `CCG_DIV_W
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        system_input_clock,
	input  wire logic [1:0]  ratio_select_pins,
	input  wire logic        clock_doubler_n,
	output logic             core_clock,
	output logic             external_port_system_clock,
	output logic             link_clock,
	output logic             serial_clock,
	output logic             sdram_clock,
	output logic             spi_clock,
	output logic             locked
);
	// Strap code to core ratio; doubling turns 3 and 4 into 6 and 8
	function automatic logic [3:0] core_ratio_f(input logic [1:0] sel, input logic dbl);
		logic [3:0] base;
		base = (sel == 2'h1) ? `CCG_BASE_3 : (sel == 2'h2) ? `CCG_BASE_4 : `CCG_BASE_2;
		return dbl ? {base[2:0], 1'b0} : base;
	endfunction

	// Byte-lane merge for Wishbone writes
	function automatic logic [31:0] merge_f(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// Pin synchronisers; stage 0 feeds only stage 1
	logic [2:0] system_input_clock_sync_q;
	logic [2:0] strap_s1_q;
	logic [2:0] strap_s2_q;
	always_ff @(posedge sys_clk) begin
		system_input_clock_sync_q <= {system_input_clock_sync_q[1:0], system_input_clock};
		strap_s1_q   <= {clock_doubler_n, ratio_select_pins};
		strap_s2_q   <= strap_s1_q;
	end

	logic       in_edge;
	logic       cap_now;
	logic       cap_done_q;
	logic [3:0] core_ratio_q;
	logic [1:0] ext_ratio_q;
	assign in_edge = system_input_clock_sync_q[1] & ~system_input_clock_sync_q[2];
	assign cap_now = ~cap_done_q;

	// Straps caught on the first edge after release, then frozen until reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cap_done_q   <= 1'b0;
			core_ratio_q <= `CCG_BASE_2;
			ext_ratio_q  <= `CCG_RST_EXT;
		end else if (cap_now) begin
			cap_done_q   <= 1'b1;
			core_ratio_q <= core_ratio_f(strap_s2_q[1:0], ~strap_s2_q[2]);
			ext_ratio_q  <= strap_s2_q[2] ? 2'h1 : 2'h2;
		end
	end

	// Input period in sys_clk cycles; saturation means the input clock stopped
	logic [PER_W-1:0] per_cnt_q;
	logic [PER_W-1:0] period_q;
	logic             per_sat;
	assign per_sat = &per_cnt_q;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			per_cnt_q <= '0;
		end else if (in_edge) begin
			per_cnt_q <= PER_W'(1);
		end else if (!per_sat) begin
			per_cnt_q <= per_cnt_q + 1'b1;
		end
	end

	// Lock sequence: wait for straps, measure one period, then run
	ccg_state_type state_q;
	ccg_state_type state_d;
	logic          run;
	logic          per_ok;
	assign per_ok = per_cnt_q >= PER_W'(`CCG_MIN_PER);
	assign run    = (state_q == CCG_RUN);
	always_comb begin
		state_d = state_q;
		case (state_q)
			CCG_WAIT: begin
				if (cap_done_q && in_edge) begin
					state_d = CCG_MEAS;
				end
			end
			CCG_MEAS: begin
				if (in_edge && per_ok) begin
					state_d = CCG_RUN;
				end else if (per_sat) begin
					state_d = CCG_WAIT;
				end
			end
			CCG_RUN: begin
				if (per_sat || (in_edge && !per_ok)) begin
					state_d = CCG_WAIT;
				end
			end
			default: begin
				state_d = CCG_WAIT;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q  <= CCG_WAIT;
			period_q <= '1;
			locked   <= 1'b0;
		end else begin
			state_q <= state_d;
			locked  <= (state_d == CCG_RUN);
			if (in_edge && state_q != CCG_WAIT) begin
				period_q <= per_cnt_q;   // Tracks slow drift of the input clock
			end
		end
	end

	// Two phase accumulators: 2*ratio half-periods per input period.
	// Jitter is one sys_clk; the trade for having no analogue loop here.
	logic [PER_W:0] nco_inc [2];
	logic           nco_tick [2];
	logic           nco_clk_q [2];
	assign nco_inc[0] = (PER_W+1)'({core_ratio_q, 1'b0});
	assign nco_inc[1] = (PER_W+1)'({ext_ratio_q, 1'b0});

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_nco
			logic [PER_W:0] acc_q;
			logic [PER_W:0] sum;
			assign sum         = acc_q + nco_inc[g];
			assign nco_tick[g] = run & (sum >= {1'b0, period_q});
			always_ff @(posedge sys_clk) begin
				if (!rst_n || !run) begin
					acc_q        <= '0;
					nco_clk_q[g] <= 1'b0;
				end else if (nco_tick[g]) begin
					acc_q        <= sum - {1'b0, period_q};
					nco_clk_q[g] <= ~nco_clk_q[g];
				end else begin
					acc_q <= sum;
				end
			end
		end
	endgenerate
	assign core_clock                 = nco_clk_q[0];
	assign external_port_system_clock = nco_clk_q[1];

	// Wishbone slave: one-cycle registered answer, unmapped reads give zero
	logic        wb_ack_q;
	logic [31:0] wb_dat_q;
	logic        bus_acc;
	logic        bus_wr;
	logic [7:0]  adr_w;
	logic        hit_ctrl;
	logic        hit_serial;
	logic        hit_spi;
	logic        hit_stat;
	assign bus_acc    = wb_cyc_i & wb_stb_i & ~wb_ack_q;
	assign bus_wr     = bus_acc & wb_we_i;
	assign adr_w      = {wb_adr_i[7:2], 2'b00};
	assign hit_ctrl   = (adr_w == `CCG_OFS_CTRL);
	assign hit_serial = (adr_w == `CCG_OFS_SERIAL);
	assign hit_spi    = (adr_w == `CCG_OFS_SPI);
	assign hit_stat   = (adr_w == `CCG_OFS_STATUS);

	logic [1:0]       link_div_q;
	logic             sdram_sel_q;
	logic [DIV_W-1:0] serial_div_q;
	logic [DIV_W-1:0] spi_div_q;
	logic [31:0]      ctrl_word;
	logic [31:0]      stat_word;
	logic [31:0]      rd_data;
	logic [31:0]      ctrl_new;
	assign ctrl_word = {23'h0, sdram_sel_q, 6'h0, link_div_q};
	assign stat_word = {16'(period_q), 7'h0, locked, 2'h0, ext_ratio_q, core_ratio_q};
	assign ctrl_new  = merge_f(ctrl_word, wb_dat_i, wb_sel_i);
	assign rd_data   = hit_ctrl   ? ctrl_word :
	                   hit_serial ? 32'(serial_div_q) :
	                   hit_spi    ? 32'(spi_div_q) :
	                   hit_stat   ? stat_word : 32'h0;

	// Register writes take effect at the acking edge
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			link_div_q   <= `CCG_RST_LINK;
			sdram_sel_q  <= `CCG_RST_SDRAM;
			serial_div_q <= DIV_W'(`CCG_RST_SERIAL);
			spi_div_q    <= DIV_W'(`CCG_RST_SPI);
		end else if (bus_wr) begin
			if (hit_ctrl) begin
				link_div_q  <= ctrl_new[`CCG_LINK_LSB +: 2];
				sdram_sel_q <= ctrl_new[`CCG_SDRAM_BIT];
			end
			if (hit_serial) begin
				serial_div_q <= DIV_W'(merge_f(32'(serial_div_q), wb_dat_i, wb_sel_i));
			end
			if (hit_spi) begin
				spi_div_q <= DIV_W'(merge_f(32'(spi_div_q), wb_dat_i, wb_sel_i));
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wb_ack_q <= 1'b0;
			wb_dat_q <= 32'h0;
		end else begin
			wb_ack_q <= bus_acc;
			wb_dat_q <= bus_acc ? rd_data : 32'h0;
		end
	end
	assign wb_ack_o = wb_ack_q;
	assign wb_dat_o = wb_dat_q;

	// Port dividers all count core half-periods, so link, serial, sdram and spi clocks follow the core
	logic [DIV_W-1:0] ratio_w [4];
	logic             port_clk [4];
	logic             div_rst_n;
	assign ratio_w[0] = DIV_W'({1'b0, link_div_q} + 3'h1);
	assign ratio_w[1] = serial_div_q;
	assign ratio_w[2] = sdram_sel_q ? DIV_W'(2) : DIV_W'(1);
	assign ratio_w[3] = spi_div_q;
	assign div_rst_n  = rst_n & run;   // Port clocks park low while unlocked
	ccg_div_if #(.W(DIV_W)) div_bus [4] ();
	generate
		for (g = 0; g < 4; g++) begin : g_div
			assign div_bus[g].tick  = nco_tick[0];
			assign div_bus[g].ratio = ratio_w[g];
			assign port_clk[g]      = div_bus[g].div_clk;
			ccg_div #(.W(DIV_W)) u_div (
				.sys_clk (sys_clk),
				.rst_n   (div_rst_n),
				.bus     (div_bus[g])
			);
		end
	endgenerate
	assign link_clock   = port_clk[0];
	assign serial_clock = port_clk[1];
	assign sdram_clock  = port_clk[2];
	assign spi_clock    = port_clk[3];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_ratio_held: assert property (cap_done_q && $past(cap_done_q) |-> $stable(core_ratio_q))
		else $error("core ratio changed after capture");
	a_strap_take: assert property (rst_n && cap_now |=>   // Release edge still resets
		core_ratio_q == core_ratio_f($past(strap_s2_q[1:0]), !$past(strap_s2_q[2])))
		else $error("core ratio does not match straps");
	a_core_legal: assert property (cap_done_q |->
		core_ratio_q inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h8})
		else $error("illegal core ratio");
	a_ext_legal: assert property (cap_done_q |-> ext_ratio_q inside {2'h1, 2'h2})
		else $error("illegal external clock ratio");
	a_core_toggle: assert property (nco_tick[0] |=> core_clock != $past(core_clock))
		else $error("core clock missed a tick");
	a_idle_quiet: assert property (!run |=> !core_clock && !external_port_system_clock)
		else $error("clock running while unlocked");
	a_link_range: assert property (ratio_w[0] >= DIV_W'(1) && ratio_w[0] <= DIV_W'(4))
		else $error("link ratio out of range");
	a_sdram_write: assert property (bus_wr && hit_ctrl && wb_sel_i[1] |=>
		ratio_w[2] == ($past(wb_dat_i[8]) ? DIV_W'(2) : DIV_W'(1)))
		else $error("sdram ratio not taken from write");
	a_serial_write: assert property (bus_wr && hit_serial && (&wb_sel_i[1:0]) |=>
		ratio_w[1] == DIV_W'($past(wb_dat_i)))
		else $error("serial ratio not taken from write");
	a_spi_write: assert property (bus_wr && hit_spi && (&wb_sel_i[1:0]) |=>
		ratio_w[3] == DIV_W'($past(wb_dat_i)))
		else $error("spi ratio not taken from write");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");

	c_doubled: cover property (cap_now && !strap_s2_q[2]);
	c_lock: cover property (state_q == CCG_MEAS ##1 state_q == CCG_RUN);
	c_link_tick: cover property (run && link_div_q == 2'h3 && $rose(link_clock));
	c_serial_wr: cover property (bus_wr && hit_serial);
endmodule
`default_nettype wire

// File: rtl/ccg_cfg.svh
`ifndef CCG_CFG_SVH
`define CCG_CFG_SVH

// Register byte offsets
`define CCG_OFS_CTRL   8'h00
`define CCG_OFS_SERIAL 8'h04
`define CCG_OFS_SPI    8'h08
`define CCG_OFS_STATUS 8'h0c
// Control register fields
`define CCG_LINK_LSB   0
`define CCG_SDRAM_BIT  8
// Reset values
`define CCG_RST_LINK   2'h0
`define CCG_RST_SDRAM  1'b0
`define CCG_RST_SERIAL 16'h0004
`define CCG_RST_SPI    16'h0004
`define CCG_RST_EXT    2'h1
// Base core ratios per strap code, before doubling
`define CCG_BASE_2     4'h2
`define CCG_BASE_3     4'h3
`define CCG_BASE_4     4'h4
// Widths and limits
`define CCG_PER_W      16
`define CCG_DIV_W      16
`define CCG_MIN_PER    16'h0010
`endif

// File: rtl/ccg_pkg.sv
package ccg_pkg;
	// Lock sequencing of the clock generator
	typedef enum logic [2:0] {
		CCG_WAIT = 3'b001,
		CCG_MEAS = 3'b010,
		CCG_RUN  = 3'b100
	} ccg_state_type;
endpackage

// File: rtl/ccg_div_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ccg_div_if #(
	parameter int W = 16
);
	logic         tick;
	logic [W-1:0] ratio;
	logic         div_clk;
	modport ctrl (output tick, output ratio, input div_clk);
	modport div  (input tick, input ratio, output div_clk);
endinterface
`default_nettype wire

// File: rtl/ccg_div.sv
`timescale 1ns/1ps
`default_nettype none
module ccg_div #(
	parameter int W = 16
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	ccg_div_if.div    bus
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_nx;
	logic         clk_q;
	logic         hit;

	// One core half-period per tick; toggling every ratio ticks gives period ratio x core
	assign cnt_nx = cnt_q + 1'b1;
	assign hit    = bus.tick & (cnt_nx >= bus.ratio);   // Ratio zero acts as one
	assign bus.div_clk = clk_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			clk_q <= 1'b0;
		end else if (hit) begin
			cnt_q <= '0;
			clk_q <= ~clk_q;
		end else if (bus.tick) begin
			cnt_q <= cnt_nx;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_div_toggle: assert property (hit |=> clk_q != $past(clk_q))
		else $error("divider missed its toggle");
	a_div_hold: assert property (!hit |=> clk_q == $past(clk_q))
		else $error("divider toggled without reaching its ratio");
endmodule
`default_nettype wire

// File: sim/ccg_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Oscillator on the input clock pin
module ccg_osc_model (
	input  wire logic [15:0] half_ns,
	output logic             osc
);
	// Odd start offset keeps its phase apart from sys_clk
	initial begin
		osc = 1'b0;
		#7;
		forever begin
			#(half_ns);
			osc = ~osc;
		end
	end
endmodule
`default_nettype wire

// File: sim/ccg_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccg_cfg.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module ccg_top_test;
	logic        sys_clk;
	logic        rst_n;
	logic        cyc;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	wire  [31:0] rdat;
	wire         ack;
	wire         osc;
	wire  [5:0]  clks;
	wire         locked;
	logic [15:0] half;
	logic [1:0]  straps;
	logic        dbl_n;
	logic [31:0] q;
	int          n_fail;
	int          total_checks;
	int          ticks = 0;
	int          cnt [6];

	ccg_osc_model i_osc (.half_ns(half), .osc(osc));

	ccg_top i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .system_input_clock(osc),
		.ratio_select_pins(straps), .clock_doubler_n(dbl_n),
		.core_clock(clks[0]), .external_port_system_clock(clks[1]),
		.link_clock(clks[2]), .serial_clock(clks[3]), .sdram_clock(clks[4]),
		.spi_clock(clks[5]), .locked(locked)
	);

	task conclude;
		if (n_fail == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge sys_clk) begin
		ticks <= ticks + 1;
		if (ticks == 30000) begin
			n_fail++;
			conclude();
		end
	end

	// One classic cycle; cyc doubles as stb
	task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1);
		q = rdat;
		`CHK(n, 2) // Ack stands in the cycle after the taking edge
		cyc <= 1'b0;
		we <= 1'b0;
	endtask

	// Straps held over the whole reset pulse
	task restart(input logic [1:0] s, input logic dn);
		int n;
		@(posedge sys_clk);
		rst_n <= 1'b0;
		straps <= s;
		dbl_n <= dn;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (locked !== 1'b1 && n < 600);
		`CHK(locked, 1'b1)
		repeat (128) @(posedge sys_clk);
	endtask

	// Rising edges of every clock output over four input periods
	task measure;
		logic [5:0] prev;
		cnt = '{default: 0};
		prev = clks;
		repeat (256) begin
			@(posedge sys_clk);
			for (int i = 0; i < 6; i++) begin
				if (clks[i] === 1'b1 && prev[i] === 1'b0) begin
					cnt[i]++;
				end
			end
			prev = clks;
		end
	endtask

	// Count within one edge of 256 cycles over per_x/x
	function automatic logic near(int c, int num, int den);
		return (c * den - num <= den) && (num - c * den <= den);
	endfunction

	task t_straps;
		logic [1:0] sv [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
		logic       dn [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
		int         r [6] = '{2, 3, 4, 2, 6, 8};
		for (int k = 0; k < 6; k++) begin
			restart(sv[k], dn[k]);
			straps <= ~sv[k];
			dbl_n <= ~dn[k];
			wb(1'b0, `CCG_OFS_STATUS, 4'hf, 32'h0);
			`CHK(q[3:0], r[k][3:0])
			`CHK(q[5:4], dn[k] ? 2'h1 : 2'h2)
			measure();
			`CHK(near(cnt[0], 256 * r[k], 64), 1'b1)
			`CHK(near(cnt[1], dn[k] ? 256 : 512, 64), 1'b1)
		end
	endtask

	// Core period is 8 cycles here
	task t_regs;
		wb(1'b0, `CCG_OFS_CTRL, 4'hf, 32'h0);
		`CHK(q, 32'h0)
		wb(1'b0, `CCG_OFS_SERIAL, 4'hf, 32'h0);
		`CHK(q[15:0], `CCG_RST_SERIAL)
		wb(1'b0, `CCG_OFS_SPI, 4'hf, 32'h0);
		`CHK(q[15:0], `CCG_RST_SPI)
		wb(1'b1, 8'h10, 4'hf, 32'hffff_ffff);
		wb(1'b0, 8'h10, 4'hf, 32'h0);
		`CHK(q, 32'h0)
		wb(1'b1, `CCG_OFS_STATUS, 4'hf, 32'h0);
		wb(1'b0, `CCG_OFS_STATUS, 4'hf, 32'h0);
		`CHK(q[3:0], 4'h8)
		measure();
		`CHK(near(cnt[2], 256, 8), 1'b1)
		`CHK(near(cnt[3], 256, 32), 1'b1)
		`CHK(near(cnt[4], 256, 8), 1'b1)
		`CHK(near(cnt[5], 256, 32), 1'b1)
	endtask

	// Every link code; sdram alternates; spi 0 acts as 1
	task t_divs;
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, `CCG_OFS_CTRL, 4'hf, {23'h0, k[0], 6'h0, k[1:0]});
			wb(1'b1, `CCG_OFS_SERIAL, 4'h3, {16'hffff, 16'(k + 1)});
			wb(1'b1, `CCG_OFS_SPI, 4'hf, 32'(k));
			wb(1'b0, `CCG_OFS_CTRL, 4'hf, 32'h0);
			`CHK({q[8], q[1:0]}, {k[0], k[1:0]})
			wb(1'b0, `CCG_OFS_SERIAL, 4'hf, 32'h0);
			`CHK(q[15:0], 16'(k + 1))
			measure();
			`CHK(near(cnt[2], 256, 8 * (k + 1)), 1'b1)
			`CHK(near(cnt[3], 256, 8 * (k + 1)), 1'b1)
			`CHK(near(cnt[4], 256, 8 * (1 + k % 2)), 1'b1)
			`CHK(near(cnt[5], 256, 8 * (k == 0 ? 1 : k)), 1'b1)
		end
	endtask

	// Input clock too fast to lock: generator must drop out
	task t_fast;
		int n;
		half <= 16'd100;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (locked !== 1'b0 && n < 300);
		repeat (8) @(posedge sys_clk);
		`CHK({locked, clks}, 7'h0)
		half <= 16'd800;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	initial begin
		rst_n = 1'b0;
		cyc = 1'b0;
		we = 1'b0;
		adr = 8'h0;
		sel = 4'h0;
		wdat = 32'h0;
		half = 16'd800;
		straps = 2'h0;
		dbl_n = 1'b1;
		n_fail = 0;
		total_checks = 0;
		t_straps();
		t_regs();
		t_divs();
		t_fast();
		conclude();
	end
endmodule
`default_nettype wire
